// ===== src/utt_pkg.sv
/*
  Package for the USB throughput tuning block: register offset, field
  positions, reset values and the OUT watermark level table.
  Assumes a 32-bit word-addressed register port from the host core.
*/
`default_nettype none
package utt_pkg;
  localparam logic [11:0] UTT_TUNING_OFFSET = 12'h06c;
  localparam int          UTT_WMD_BIT       = 0;
  localparam int          UTT_RBD_BIT       = 1;
  localparam logic [31:0] UTT_TUNING_RESET  = 32'h0000_0003;
  localparam logic [31:0] UTT_TUNING_WMASK  = 32'h0000_0003;
  localparam int          UTT_LEVELS        = 6;
  localparam logic [10:0] UTT_LEVEL_TAB [UTT_LEVELS] = '{
    11'h0bf, 11'h0ff, 11'h17f, 11'h1ff, 11'h27f, 11'h2ff};

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } utt_req_s;

  typedef struct packed {
    logic        valid;
    logic        bulk_or_int;
    logic [10:0] size;
  } utt_pkt_s;
endpackage : utt_pkg
`default_nettype wire

// ===== src/utt_tuning.sv
/*
  Throughput tuning register with the IN ring buffering and OUT watermark
  start decisions it steers.
  Assumes the host core presents register accesses as a one-cycle request
  struct and reports packet progress as synchronous pulses and counts.
*/
`default_nettype none
// Summary of operation
// - The tuning register is a 32-bit read/write word at offset 6Ch with bits 31 to 2 reserved at zero.
// - Bit 1 resets to one and, while zero, lets IN ring buffering run.
// - With ring buffering on, the next IN packet starts as soon as the previous one is received.
// - Bit 0 resets to one and, while zero, puts the OUT watermark into effect.
// - The watermark applies only to bulk and interrupt OUT transfers.
// - With the watermark on, an OUT packet starts once fetched bytes reach the level just below its size, or its full size if no table level is below it.
// - With the strap pin high, the ring buffer disable bit reads one always.
// - With the strap pin high, the watermark disable bit reads one always.
module utt_tuning
  import utt_pkg::*;
#(
  parameter int N_LEVELS = UTT_LEVELS
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        tuning_strap_pin,
  input  wire utt_req_s    req,
  output logic [31:0]      rdata_r,
  output logic             rvalid_r,
  input  wire logic        in_pkt_done,
  input  wire logic        in_drain_done,
  output logic             in_start_r,
  input  wire utt_pkt_s    out_pkt,
  input  wire logic [10:0] out_fetched,
  output logic             out_start_r,
  output logic             ring_buffer_disable_r,
  output logic             watermark_disable_r
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // Only the levels held in the package table can be served.
  if (N_LEVELS < 1 || N_LEVELS > UTT_LEVELS) begin : g_bad_levels
    $error("N_LEVELS must lie between 1 and the level table size");
  end

  // ---------------------------------------------------------------
  // Register
  // ---------------------------------------------------------------
  logic hit;
  logic [31:0] reg_view;
  assign hit = (req.addr == UTT_TUNING_OFFSET);

  // Strap forces both disables; reserved bits store nothing and read zero.
  // The strap is also ORed in here so a read in its first cycle shows one.
  always_comb begin
    reg_view = '0;
    reg_view[UTT_RBD_BIT] = ring_buffer_disable_r | tuning_strap_pin;
    reg_view[UTT_WMD_BIT] = watermark_disable_r | tuning_strap_pin;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ring_buffer_disable_r <= UTT_TUNING_RESET[UTT_RBD_BIT];
      watermark_disable_r   <= UTT_TUNING_RESET[UTT_WMD_BIT];
    end else if (tuning_strap_pin) begin
      ring_buffer_disable_r <= 1'b1;
      watermark_disable_r   <= 1'b1;
    end else if (req.wr && hit) begin
      ring_buffer_disable_r <= req.wdata[UTT_RBD_BIT];
      watermark_disable_r   <= req.wdata[UTT_WMD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.rd;
      rdata_r  <= (req.rd && hit) ? reg_view : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // IN ring buffering
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_start_r <= 1'b0;
    end else if (!ring_buffer_disable_r) begin
      in_start_r <= in_pkt_done;
    end else begin
      in_start_r <= in_drain_done;
    end
  end

  // ---------------------------------------------------------------
  // OUT watermark
  // ---------------------------------------------------------------
  logic [10:0] level;
  logic        have_level;
  logic        wm_ok;

  // Largest table level strictly below the packet size.
  always_comb begin
    level      = '0;
    have_level = 1'b0;
    for (int i = 0; i < N_LEVELS; i++) begin
      if (UTT_LEVEL_TAB[i] < out_pkt.size) begin
        level      = UTT_LEVEL_TAB[i];
        have_level = 1'b1;
      end
    end
  end

  assign wm_ok = !watermark_disable_r && out_pkt.bulk_or_int && have_level;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_start_r <= 1'b0;
    end else if (!out_pkt.valid) begin
      out_start_r <= 1'b0;
    end else if (wm_ok) begin
      out_start_r <= (out_fetched >= level);
    end else begin
      out_start_r <= (out_fetched >= out_pkt.size);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_strap_forces;
    @(posedge clk) disable iff (sys_rst)
      tuning_strap_pin |=> ring_buffer_disable_r && watermark_disable_r;
  endproperty
  a_strap_forces: assert property (p_strap_forces) else $error("strap did not force disables");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && hit) |=> rdata_r[31:2] == 30'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_reset_ones;
    @(posedge clk) $fell(sys_rst) |-> ring_buffer_disable_r && watermark_disable_r;
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("disables not one after reset");

  property p_write_wmd;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && hit && !tuning_strap_pin)
        |=> watermark_disable_r == $past(req.wdata[UTT_WMD_BIT]);
  endproperty
  a_write_wmd: assert property (p_write_wmd) else $error("watermark disable write lost");

  property p_ring_start;
    @(posedge clk) disable iff (sys_rst)
      (!ring_buffer_disable_r && in_pkt_done) |=> in_start_r;
  endproperty
  a_ring_start: assert property (p_ring_start) else $error("ring start missing");

  property p_no_ring_when_off;
    @(posedge clk) disable iff (sys_rst)
      (ring_buffer_disable_r && !in_drain_done) |=> !in_start_r;
  endproperty
  a_no_ring_when_off: assert property (p_no_ring_when_off) else $error("early IN start");

  property p_wm_type;
    @(posedge clk) disable iff (sys_rst)
      (out_pkt.valid && !out_pkt.bulk_or_int && out_fetched < out_pkt.size) |=> !out_start_r;
  endproperty
  a_wm_type: assert property (p_wm_type) else $error("watermark used on wrong type");

  property p_wm_start;
    @(posedge clk) disable iff (sys_rst)
      (out_pkt.valid && wm_ok && out_fetched >= level) |=> out_start_r;
  endproperty
  a_wm_start: assert property (p_wm_start) else $error("watermark start missing");

  property p_full_fetch;
    @(posedge clk) disable iff (sys_rst)
      (out_pkt.valid && watermark_disable_r && out_fetched < out_pkt.size) |=> !out_start_r;
  endproperty
  a_full_fetch: assert property (p_full_fetch) else $error("start before full fetch");

  property p_write_rbd;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && hit && !tuning_strap_pin)
        |=> ring_buffer_disable_r == $past(req.wdata[UTT_RBD_BIT]);
  endproperty
  a_write_rbd: assert property (p_write_rbd) else $error("ring disable write lost");

  property p_rvalid_pulse;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> rvalid_r == $past(req.rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not one cycle");

  property p_write_miss;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && req.addr != UTT_TUNING_OFFSET && !tuning_strap_pin)
        |=> $stable(ring_buffer_disable_r) && $stable(watermark_disable_r);
  endproperty
  a_write_miss: assert property (p_write_miss) else $error("write to other offset landed");

  property p_strap_reads_one;
    @(posedge clk) disable iff (sys_rst)
      (tuning_strap_pin && req.rd && hit)
        |=> rdata_r[UTT_WMD_BIT] && rdata_r[UTT_RBD_BIT];
  endproperty
  a_strap_reads_one: assert property (p_strap_reads_one) else $error("strap read not one");

  property p_ring_idle;
    @(posedge clk) disable iff (sys_rst)
      (!ring_buffer_disable_r && !in_pkt_done) |=> !in_start_r;
  endproperty
  a_ring_idle: assert property (p_ring_idle) else $error("IN start without packet");

  property p_drain_start;
    @(posedge clk) disable iff (sys_rst)
      (ring_buffer_disable_r && in_drain_done) |=> in_start_r;
  endproperty
  a_drain_start: assert property (p_drain_start) else $error("IN start after drain missing");

  property p_below_levels;
    @(posedge clk) disable iff (sys_rst)
      (out_pkt.valid && out_fetched < UTT_LEVEL_TAB[0] && out_fetched < out_pkt.size)
        |=> !out_start_r;
  endproperty
  a_below_levels: assert property (p_below_levels) else $error("OUT start below levels");

endmodule : utt_tuning
`default_nettype wire

// ===== testbench/utt_host.sv
/* Host register access model; assumes reads answer a cycle later. */
`default_nettype none
module utt_host import utt_pkg::*; (
  input  wire logic        clk,
  input  wire logic [31:0] rdata_r,
  input  wire logic        rvalid_r,
  output var  utt_req_s    req
);
  timeunit 1ns / 1ps;
  initial req = '0;
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] d);
    @(posedge clk) req <= '{w, ~w, a, v & UTT_TUNING_WMASK};
    @(posedge clk) req <= '0;
    #1 d = rvalid_r ? rdata_r : 32'hdead_beef;
  endtask : acc
endmodule : utt_host
`default_nettype wire

// ===== testbench/usb_throughput_tuning_tb_top.sv
/* Tuning block bench; assumes utt_host drives req. */
`default_nettype none
module usb_throughput_tuning_tb_top import utt_pkg::*;;
  timeunit 1ns / 1ps;
  logic        clk = 0, sys_rst = 1, strap = 0, ipd = 0, idd = 0, rvalid, ist, ost, ring_buffer_disable, watermark_disable;
  logic [31:0] rdata, d;
  logic [10:0] fet = '0;
  utt_pkt_s    pkt = '0;
  utt_req_s    req;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  int          lv [6] = '{191, 255, 383, 511, 639, 767};
  always #2 clk = ~clk;
  utt_host i_utt_host (.clk(clk), .rdata_r(rdata), .rvalid_r(rvalid), .req(req));
  utt_tuning i_utt_tuning (.clk(clk), .sys_rst(sys_rst), .tuning_strap_pin(strap), .req(req),
    .rdata_r(rdata), .rvalid_r(rvalid), .in_pkt_done(ipd), .in_drain_done(idd), .in_start_r(ist),
    .out_pkt(pkt), .out_fetched(fet), .out_start_r(ost), .ring_buffer_disable_r(ring_buffer_disable),
    .watermark_disable_r(watermark_disable));
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
  endtask : chk
  task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] e);
    i_utt_host.acc(1'b0, a, 32'h0, d);
    chk(s, e, d);
    chk(s, e, {30'h0, ring_buffer_disable, watermark_disable});
  endtask : rchk
  task automatic drv(input logic [1:0] i, e, input logic v, b, input int z, f, input string s);
    @(posedge clk) {ipd, idd, pkt, fet} <= {i, v, b, 11'(z), 11'(f)};
    @(posedge clk) {ipd, idd} <= 2'b00;
    #1 chk(s, {30'h0, e}, {30'h0, ist, ost});
  endtask : drv
  task automatic t_reg;
    rchk("reset", 12'h06c, 32'h3);
    i_utt_host.acc(1'b1, 12'h068, 32'h0, d);
    rchk("decode", 12'h06c, 32'h3);
    i_utt_host.acc(1'b1, 12'h06c, 32'h0, d);
    rchk("cleared", 12'h06c, 32'h0);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_in;
    drv(2'b10, 2'b10, 1'b0, 1'b0, 0, 0, "ring");
    i_utt_host.acc(1'b1, 12'h06c, 32'h2, d);
    drv(2'b10, 2'b00, 1'b0, 1'b0, 0, 0, "no ring");
    drv(2'b01, 2'b10, 1'b0, 1'b0, 0, 0, "drained");
    $display("t_in done");
  endtask : t_in
  task automatic t_out;
    foreach (lv[i]) begin
      drv(2'b00, 2'b01, 1'b1, 1'b1, lv[i] + 1, lv[i], "level");
      drv(2'b00, 2'b00, 1'b1, 1'b1, lv[i] + 1, lv[i] - 1, "below");
    end
    drv(2'b00, 2'b01, 1'b1, 1'b1, 1024, 767, "pkt 1024");
    drv(2'b00, 2'b00, 1'b1, 1'b0, 1024, 767, "other type");
    i_utt_host.acc(1'b1, 12'h06c, 32'h1, d);
    drv(2'b00, 2'b00, 1'b1, 1'b1, 1024, 767, "wm off");
    $display("t_out done");
  endtask : t_out
  task automatic t_strap;
    @(posedge clk) strap <= 1'b1;
    i_utt_host.acc(1'b1, 12'h06c, 32'h0, d);
    rchk("strap", 12'h06c, 32'h3);
    $display("t_strap done");
  endtask : t_strap
  task automatic complete_run(input int t);
    n_mismatch += t;
    $display("compares %0d bad %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) if (++cyc == 3000) complete_run(1);
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reg();
    t_in();
    t_out();
    t_strap();
    complete_run(0);
  end
endmodule : usb_throughput_tuning_tb_top
`default_nettype wire
